// file: verilog/ptm_pkg.sv
package ptm_pkg;
  localparam int ADDR_W = 23;
  localparam int CNT_W = 8;
  localparam int DEPTH = 16;
  localparam int PTR_W = 4;
  localparam logic [5:0] TC_DIRECT = 6'h03;
  localparam logic [5:0] TC_INDIRECT = 6'h04;
  localparam logic [5:0] TC_ERROR = 6'h08;
  localparam logic [5:0] TC_CORRECT = 6'h0A;
  localparam logic [5:0] TC_DSYNC = 6'h0B;
  localparam logic [5:0] TC_DSYNC_CNT = 6'h0C;
  localparam logic [5:0] TC_ISYNC = 6'h0D;
  localparam logic [5:0] TC_ISYNC_CNT = 6'h0E;
  localparam logic [5:0] TC_FULL = 6'h1B;
  localparam logic [5:0] TC_ISYNC_CC = 6'h3B;
  localparam logic [5:0] TC_DSYNC_CC = 6'h3C;
  localparam logic [3:0] RES_SEQ_FULL = 4'h0;
  localparam logic [3:0] ERR_OVERRUN = 4'h7;
  localparam logic [8:0] ICNT_MAX = 9'h100;
  localparam logic [7:0] SYNC_PERIOD = 8'hFF;
  localparam logic [1:0] EVT_SYNC = 2'h0;
  // register map
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STAT = 8'h04;
  localparam logic [7:0] OFS_MSGS = 8'h08;
  localparam int B_EN = 0;
  localparam int B_FMT = 1;
  localparam int B_EC0 = 2;
  // message record: tcode, count/field, bit ptr, address, address length
  localparam int MSG_W = 6 + CNT_W + 6 + ADDR_W + 5;
  typedef enum logic [1:0] {PTM_IDLE, PTM_ERRQ} ptm_state_t;
endpackage

// file: verilog/ptm_encoder.sv
module ptm_encoder (
  // clock and reset
  input wire logic mclk,
  input wire logic arst_n,
  // processor activity, same clock
  input wire logic instr_seq,
  input wire logic br_direct,
  input wire logic br_indirect,
  input wire logic [22:0] br_target,
  input wire logic [5:0] br_bitptr,
  input wire logic mispredict,
  input wire logic exception,
  input wire logic [7:0] exc_unreported,
  input wire logic watchpoint,
  input wire logic fetch_sync,
  input wire logic compressed_mode,
  input wire logic low_power,
  input wire logic background_debug_mode,
  input wire logic sys_reset,
  // external pin
  input wire logic event_in_pin,
  // output queue drain
  output logic msg_valid,
  input wire logic msg_ready,
  output logic [5:0] msg_tcode,
  output logic [7:0] msg_count,
  output logic [5:0] msg_bitptr,
  output logic [22:0] msg_addr,
  output logic [4:0] msg_addr_len,
  // axi4-lite slave
  input wire logic [7:0] s_awaddr,
  input wire logic s_awvalid,
  output logic s_awready,
  input wire logic [31:0] s_wdata,
  input wire logic [3:0] s_wstrb,
  input wire logic s_wvalid,
  output logic s_wready,
  output logic [1:0] s_bresp,
  output logic s_bvalid,
  input wire logic s_bready,
  input wire logic [7:0] s_araddr,
  input wire logic s_arvalid,
  output logic s_arready,
  output logic [31:0] s_rdata,
  output logic [1:0] s_rresp,
  output logic s_rvalid,
  input wire logic s_rready
);
  localparam int MW = ptm_pkg::MSG_W;

  function automatic logic [4:0] sig_len(input logic [22:0] v);
    logic [4:0] n;
    n = 5'h01;
    for (int i = 0; i < 23; i++)
    begin
      if (v[i])
      begin
        n = 5'(i + 1);
      end
    end
    return n;
  endfunction

  function automatic logic [MW-1:0] pack(input logic [5:0] tc, input logic [7:0] c,
      input logic [5:0] bp, input logic [22:0] a);
    return {tc, c, bp, a, sig_len(a)};
  endfunction

  // event pin synchroniser
  logic evt_s1_reg, evt_s2_reg, evt_s3_reg;
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      evt_s1_reg <= 1'b0;
      evt_s2_reg <= 1'b0;
      evt_s3_reg <= 1'b0;
    end
    else
    begin
      evt_s1_reg <= event_in_pin;
      evt_s2_reg <= evt_s1_reg;
      evt_s3_reg <= evt_s2_reg;
    end
  end
  wire evt_rise = evt_s2_reg & ~evt_s3_reg;

  // control register
  logic [31:0] ctrl_reg, ctrl_next;
  wire trace_en = ctrl_reg[ptm_pkg::B_EN];
  wire fmt_sel = ctrl_reg[ptm_pkg::B_FMT];
  wire [1:0] ec_field = ctrl_reg[ptm_pkg::B_EC0 +: 2];

  // trace state
  logic [8:0] icnt_reg, icnt_next;
  logic [7:0] since_sync_reg, since_sync_next;
  logic [7:0] last_cnt_reg, last_cnt_next;
  logic sync_pend_reg, sync_pend_next;
  logic [22:0] ref_addr_reg, ref_addr_next;
  logic en_d_reg, lp_d_reg, bdm_d_reg, cc_d_reg, rst_d_reg;
  logic ovr_sticky_reg, ovr_sticky_next;
  logic [15:0] msg_total_reg, msg_total_next;
  localparam int DEPTH_L = ptm_pkg::DEPTH;
  logic [MW-1:0] q_mem [DEPTH_L];
  logic [ptm_pkg::PTR_W-1:0] wr_ptr_reg, wr_ptr_next, rd_ptr_reg, rd_ptr_next;
  logic [ptm_pkg::PTR_W:0] q_cnt_reg, q_cnt_next;
  typedef ptm_pkg::ptm_state_t ptm_state_t_l;
  ptm_state_t_l st_reg, st_next;

  // one message per cycle; priority overrun error > correction > branch > full
  logic push;
  logic [MW-1:0] push_msg;
  logic is_sync;
  logic [22:0] rel;
  always_comb
  begin
    icnt_next = icnt_reg;
    since_sync_next = since_sync_reg;
    last_cnt_next = last_cnt_reg;
    sync_pend_next = sync_pend_reg;
    ref_addr_next = ref_addr_reg;
    ovr_sticky_next = ovr_sticky_reg;
    push = 1'b0;
    push_msg = '0;
    is_sync = 1'b0;
    rel = br_target ^ ref_addr_reg;
    st_next = st_reg;
    if ((trace_en & ~en_d_reg) | (lp_d_reg & ~low_power)
        | (bdm_d_reg & ~background_debug_mode) | (rst_d_reg & ~sys_reset)
        | (compressed_mode ^ cc_d_reg) | fetch_sync
        | (watchpoint & trace_en)
        | (evt_rise & ec_field == ptm_pkg::EVT_SYNC))
    begin
      sync_pend_next = 1'b1;
    end
    if (trace_en)
    begin
      if (instr_seq)
      begin
        icnt_next = icnt_reg + 9'h001;
      end
      if (st_reg == ptm_pkg::PTM_ERRQ)
      begin
        // overrun error leads the flushed queue
        push = 1'b1;
        push_msg = pack(ptm_pkg::TC_ERROR, {4'h0, ptm_pkg::ERR_OVERRUN}, 6'h00, 23'h0);
        st_next = ptm_pkg::PTM_IDLE;
        sync_pend_next = 1'b1;
      end
      else if (mispredict)
      begin
        // one rewound; mispredicted branch restarts count at one
        push = 1'b1;
        push_msg = pack(ptm_pkg::TC_CORRECT, 8'h01, 6'h00, 23'h0);
        icnt_next = 9'h001;
      end
      else if (exception)
      begin
        // unreported work is excluded, faulting one included
        push = 1'b1;
        push_msg = pack(ptm_pkg::TC_CORRECT, 8'(last_cnt_reg - exc_unreported + 8'h01),
            6'h00, 23'h0);
        icnt_next = 9'h000;
      end
      else if (br_direct | br_indirect)
      begin
        // sync only lands on a taken change of flow
        is_sync = sync_pend_reg | since_sync_reg >= ptm_pkg::SYNC_PERIOD;
        push = 1'b1;
        if (is_sync)
        begin
          if (compressed_mode)
          begin
            push_msg = pack(br_direct ? ptm_pkg::TC_DSYNC_CC : ptm_pkg::TC_ISYNC_CC,
                fmt_sel ? icnt_reg[7:0] : 8'h00, br_bitptr, br_target);
          end
          else if (fmt_sel)
          begin
            push_msg = pack(br_direct ? ptm_pkg::TC_DSYNC_CNT : ptm_pkg::TC_ISYNC_CNT,
                8'(ovr_sticky_reg), 6'h00, br_target);
          end
          else
          begin
            push_msg = pack(br_direct ? ptm_pkg::TC_DSYNC : ptm_pkg::TC_ISYNC,
                {7'h00, ovr_sticky_reg}, 6'h00, br_target);
          end
          ref_addr_next = br_target;
          sync_pend_next = 1'b0;
          since_sync_next = 8'h00;
          ovr_sticky_next = 1'b0;
        end
        else if (br_indirect)
        begin
          push_msg = pack(ptm_pkg::TC_INDIRECT, icnt_reg[7:0], 6'h00, rel);
          ref_addr_next = br_target;
          since_sync_next = since_sync_reg + 8'h01;
        end
        else
        begin
          push_msg = pack(ptm_pkg::TC_DIRECT, icnt_reg[7:0], 6'h00, 23'h0);
          since_sync_next = since_sync_reg + 8'h01;
        end
        last_cnt_next = icnt_reg[7:0];
        icnt_next = 9'h000;
      end
      else if (icnt_reg == ptm_pkg::ICNT_MAX)
      begin
        push = 1'b1;
        push_msg = pack(ptm_pkg::TC_FULL, {4'h0, ptm_pkg::RES_SEQ_FULL}, 6'h00, 23'h0);
        icnt_next = {8'h00, instr_seq};
        sync_pend_next = 1'b1;
      end
    end
  end

  // queue: strictly in order
  wire pop = msg_valid & msg_ready;
  wire q_full = q_cnt_reg == 5'(ptm_pkg::DEPTH);
  logic ovr_sticky_next_q;
  always_comb
  begin
    wr_ptr_next = wr_ptr_reg;
    rd_ptr_next = rd_ptr_reg;
    q_cnt_next = q_cnt_reg;
    msg_total_next = msg_total_reg;
    if (push & q_full & st_reg != ptm_pkg::PTM_ERRQ)
    begin
      // drop the lost message; flush and queue the error next cycle
      wr_ptr_next = '0;
      rd_ptr_next = '0;
      q_cnt_next = '0;
      ovr_sticky_next_q = 1'b1;
    end
    else
    begin
      ovr_sticky_next_q = 1'b0;
      if (push)
      begin
        wr_ptr_next = wr_ptr_reg + 4'h1;
        msg_total_next = msg_total_reg + 16'h0001;
      end
      if (pop)
      begin
        rd_ptr_next = rd_ptr_reg + 4'h1;
      end
      q_cnt_next = 5'(q_cnt_reg + push - pop);
    end
  end
  wire q_do_write = push & ~(q_full & st_reg != ptm_pkg::PTM_ERRQ);

  always_ff @(posedge mclk)
  begin
    if (q_do_write)
    begin
      q_mem[wr_ptr_reg] <= push_msg;
    end
  end
  assign msg_valid = q_cnt_reg != '0;
  assign {msg_tcode, msg_count, msg_bitptr, msg_addr, msg_addr_len} = q_mem[rd_ptr_reg];

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      icnt_reg <= '0;
      since_sync_reg <= '0;
      last_cnt_reg <= '0;
      sync_pend_reg <= 1'b1;
      ref_addr_reg <= '0;
      en_d_reg <= 1'b0;
      lp_d_reg <= 1'b0;
      bdm_d_reg <= 1'b0;
      cc_d_reg <= 1'b0;
      rst_d_reg <= 1'b0;
      ovr_sticky_reg <= 1'b0;
      msg_total_reg <= '0;
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      q_cnt_reg <= '0;
      st_reg <= ptm_pkg::PTM_IDLE;
    end
    else
    begin
      icnt_reg <= icnt_next;
      since_sync_reg <= since_sync_next;
      last_cnt_reg <= last_cnt_next;
      sync_pend_reg <= sync_pend_next;
      ref_addr_reg <= ref_addr_next;
      en_d_reg <= trace_en;
      lp_d_reg <= low_power;
      bdm_d_reg <= background_debug_mode;
      cc_d_reg <= compressed_mode;
      rst_d_reg <= sys_reset;
      ovr_sticky_reg <= ovr_sticky_next | ovr_sticky_next_q;
      msg_total_reg <= msg_total_next;
      wr_ptr_reg <= wr_ptr_next;
      rd_ptr_reg <= rd_ptr_next;
      q_cnt_reg <= q_cnt_next;
      st_reg <= ovr_sticky_next_q ? ptm_pkg::PTM_ERRQ : st_next;
    end
  end

  // axi4-lite: write taken when address and data both present
  logic bvalid_reg, bvalid_next, rvalid_reg, rvalid_next;
  logic [31:0] rdata_reg, rdata_next;
  logic [1:0] bresp_reg, bresp_next, rresp_reg, rresp_next;
  wire wr_go = s_awvalid & s_wvalid & ~bvalid_reg;
  wire rd_go = s_arvalid & ~rvalid_reg;
  assign s_awready = wr_go;
  assign s_wready = wr_go;
  assign s_arready = rd_go;
  assign s_bvalid = bvalid_reg;
  assign s_bresp = bresp_reg;
  assign s_rvalid = rvalid_reg;
  assign s_rresp = rresp_reg;
  assign s_rdata = rdata_reg;
  always_comb
  begin
    ctrl_next = ctrl_reg;
    bvalid_next = bvalid_reg & ~s_bready;
    bresp_next = bresp_reg;
    rvalid_next = rvalid_reg & ~s_rready;
    rresp_next = rresp_reg;
    rdata_next = rdata_reg;
    if (wr_go)
    begin
      bvalid_next = 1'b1;
      bresp_next = 2'b00;
      if (s_awaddr == ptm_pkg::OFS_CTRL)
      begin
        for (int b = 0; b < 4; b++)
        begin
          if (s_wstrb[b])
          begin
            ctrl_next[b*8 +: 8] = s_wdata[b*8 +: 8];
          end
        end
        ctrl_next[31:4] = '0;
      end
      else if (s_awaddr != ptm_pkg::OFS_STAT && s_awaddr != ptm_pkg::OFS_MSGS)
      begin
        bresp_next = 2'b10;
      end
    end
    if (rd_go)
    begin
      rvalid_next = 1'b1;
      rresp_next = 2'b00;
      case (s_araddr)
        ptm_pkg::OFS_CTRL: rdata_next = ctrl_reg;
        ptm_pkg::OFS_STAT: rdata_next = {14'h0, q_cnt_reg, sync_pend_reg, ovr_sticky_reg,
            icnt_reg, since_sync_reg[1:0]};
        ptm_pkg::OFS_MSGS: rdata_next = {16'h0, msg_total_reg};
        default:
        begin
          rdata_next = '0;
          rresp_next = 2'b10;
        end
      endcase
    end
  end
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      ctrl_reg <= '0;
      bvalid_reg <= 1'b0;
      bresp_reg <= 2'b00;
      rvalid_reg <= 1'b0;
      rresp_reg <= 2'b00;
      rdata_reg <= '0;
    end
    else
    begin
      ctrl_reg <= ctrl_next;
      bvalid_reg <= bvalid_next;
      bresp_reg <= bresp_next;
      rvalid_reg <= rvalid_next;
      rresp_reg <= rresp_next;
      rdata_reg <= rdata_next;
    end
  end

  mispredict_corr_a: assert property (@(posedge mclk) disable iff (!arst_n)
    trace_en && st_reg == ptm_pkg::PTM_IDLE && mispredict |=> icnt_reg == 9'h001)
    else $error("count not restarted at one after mispredict");
  exception_zero_a: assert property (@(posedge mclk) disable iff (!arst_n)
    trace_en && st_reg == ptm_pkg::PTM_IDLE && !mispredict && exception |=> icnt_reg == 9'h000)
    else $error("count not cleared after exception");
  sync_ref_a: assert property (@(posedge mclk) disable iff (!arst_n)
    is_sync && push |=> ref_addr_reg == $past(br_target))
    else $error("sync did not update reference");
  overrun_err_a: assert property (@(posedge mclk) disable iff (!arst_n)
    st_reg == ptm_pkg::PTM_ERRQ && trace_en |=> q_cnt_reg >= 5'h01 && sync_pend_reg)
    else $error("overrun error not queued");
  full_sync_a: assert property (@(posedge mclk) disable iff (!arst_n)
    trace_en && st_reg == ptm_pkg::PTM_IDLE && !mispredict && !exception && !br_direct
    && !br_indirect && icnt_reg == ptm_pkg::ICNT_MAX |=> sync_pend_reg && icnt_reg <= 9'h001)
    else $error("full count did not force sync");
  period_sync_a: assert property (@(posedge mclk) disable iff (!arst_n)
    since_sync_reg >= ptm_pkg::SYNC_PERIOD && push && (br_direct | br_indirect)
    && st_reg == ptm_pkg::PTM_IDLE && !mispredict && !exception |-> is_sync)
    else $error("periodic sync missed");
  enable_sync_a: assert property (@(posedge mclk) disable iff (!arst_n)
    trace_en && !en_d_reg |=> sync_pend_reg)
    else $error("enable did not request sync");
  queue_order_a: assert property (@(posedge mclk) disable iff (!arst_n)
    msg_valid && !msg_ready && !ovr_sticky_next_q |=> msg_valid && $stable(msg_tcode))
    else $error("head message changed while stalled");
endmodule

// file: sim/ptm_tool_model.sv
module ptm_tool_model (
  // clock and reset
  input wire logic mclk,
  input wire logic arst_n,
  // queue drain handshake
  input wire logic msg_valid,
  input wire logic stall,
  output logic msg_ready
);
  timeunit 1ns;
  timeprecision 1ps;
  int seed = 32'h59A6B3E1;
  // random back-pressure, so the queue head has to stand while refused
  always @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
      msg_ready <= 1'b0;
    else
      msg_ready <= !stall && ($random(seed) % 4 != 0);
  end
endmodule

// file: sim/test_program_trace_message_encoder.sv
module test_program_trace_message_encoder;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {
    logic [5:0] tc;
    int cnt;
    bit ca;
    logic [22:0] a;
    logic [5:0] bp;
  } ptm_exp_t;
  logic mclk = 1'b0;
  logic arst_n = 1'b0;
  logic instr_seq = 1'b0, br_direct = 1'b0, br_indirect = 1'b0, mispredict = 1'b0;
  logic exception = 1'b0, watchpoint = 1'b0, fetch_sync = 1'b0, compressed_mode = 1'b0;
  logic low_power = 1'b0, background_debug_mode = 1'b0, sys_reset = 1'b0;
  logic event_in_pin = 1'b0, stall = 1'b0, msg_valid, msg_ready;
  logic [22:0] br_target = 23'h0, ref_addr = 23'h0, msg_addr;
  logic [5:0] br_bitptr = 6'h00, msg_tcode, msg_bitptr;
  logic [7:0] exc_unreported = 8'h00, msg_count, s_awaddr = 8'h00, s_araddr = 8'h00;
  logic [4:0] msg_addr_len;
  logic s_awvalid = 1'b0, s_wvalid = 1'b0, s_bready = 1'b0, s_arvalid = 1'b0, s_rready = 1'b0;
  logic [31:0] s_wdata = 32'h0, s_rdata;
  logic [3:0] s_wstrb = 4'hF;
  logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid;
  logic [1:0] s_bresp, s_rresp;
  int seed = 32'h59A6B3E1;
  int bad_count = 0, compares = 0, cycles = 0;
  bit fmt = 1'b0;
  ptm_exp_t exp_q[$];

  ptm_encoder dut (.mclk, .arst_n, .instr_seq, .br_direct, .br_indirect, .br_target,
    .br_bitptr, .mispredict, .exception, .exc_unreported, .watchpoint, .fetch_sync,
    .compressed_mode, .low_power, .background_debug_mode, .sys_reset, .event_in_pin,
    .msg_valid, .msg_ready, .msg_tcode, .msg_count, .msg_bitptr, .msg_addr, .msg_addr_len,
    .s_awaddr, .s_awvalid, .s_awready, .s_wdata, .s_wstrb, .s_wvalid, .s_wready, .s_bresp,
    .s_bvalid, .s_bready, .s_araddr, .s_arvalid, .s_arready, .s_rdata, .s_rresp, .s_rvalid,
    .s_rready);
  ptm_tool_model tool (.mclk, .arst_n, .msg_valid, .stall, .msg_ready);

  always #4 mclk = ~mclk;

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic tally_and_finish();
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  function automatic logic [4:0] sig_len(input logic [22:0] v);
    logic [4:0] n;
    n = 5'h01;
    for (int i = 0; i < 23; i++)
      if (v[i])
        n = 5'(i + 1);
    return n;
  endfunction

  function automatic logic [5:0] sync_code();
    if (compressed_mode)
      return ptm_pkg::TC_DSYNC_CC;
    return fmt ? ptm_pkg::TC_DSYNC_CNT : ptm_pkg::TC_DSYNC;
  endfunction

  task automatic note(input logic [5:0] tc, input int cnt, input bit ca,
                      input logic [22:0] a, input logic [5:0] bp);
    ptm_exp_t e;
    e.tc = tc;
    e.cnt = cnt;
    e.ca = ca;
    e.a = a;
    e.bp = bp;
    exp_q.push_back(e);
  endtask

  // expectation goes in before the pulse: the message can leave one cycle later
  task automatic fire(input bit ind, input logic [5:0] tc, input int cnt);
    logic [22:0] t;
    logic [5:0] bp;
    t = 23'($random(seed)) | 23'h1;
    bp = 6'($random(seed));
    if (tc == ptm_pkg::TC_INDIRECT)
      note(tc, cnt, 1'b1, t ^ ref_addr, bp);
    else if (tc != 6'h00)
      note(tc, cnt, tc != ptm_pkg::TC_DIRECT, t, bp);
    if (tc != 6'h00 && tc != ptm_pkg::TC_DIRECT)
      ref_addr = t;
    br_target <= t;
    br_bitptr <= bp;
    br_direct <= !ind;
    br_indirect <= ind;
    @(posedge mclk);
    br_direct <= 1'b0;
    br_indirect <= 1'b0;
    @(posedge mclk);
  endtask

  task automatic run_seq(input int n);
    if (n > 0)
    begin
      instr_seq <= 1'b1;
      repeat (n) @(posedge mclk);
      instr_seq <= 1'b0;
      @(posedge mclk);
    end
  endtask

  // k 0..5 pulse one source, 6 and 7 enter and leave compressed mode
  task automatic cause(input int k);
    {watchpoint, fetch_sync, low_power, background_debug_mode, sys_reset, event_in_pin} <=
      6'(1 << k);
    if (k >= 6)
      compressed_mode <= (k == 6);
    @(posedge mclk);
    {watchpoint, fetch_sync, low_power, background_debug_mode, sys_reset, event_in_pin} <=
      6'h00;
    repeat (4) @(posedge mclk);
  endtask

  task automatic correct(input bit exc, input int cnt);
    note(ptm_pkg::TC_CORRECT, cnt, 1'b0, 23'h0, 6'h00);
    mispredict <= !exc;
    exception <= exc;
    exc_unreported <= 8'($random(seed)) & 8'h07;
    @(posedge mclk);
    mispredict <= 1'b0;
    exception <= 1'b0;
    @(posedge mclk);
  endtask

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] resp);
    bit pa, pw, pb, ta, tw, tk;
    logic [1:0] got;
    int n;
    {pa, pw, pb, n, got} = {3'b111, 32'd0, 2'b11};
    s_awaddr <= a;
    s_wdata <= d;
    s_awvalid <= 1'b1;
    s_wvalid <= 1'b1;
    s_bready <= 1'b1;
    while ((pa || pw || pb) && n < 100)
    begin
      @(negedge mclk);
      n++;
      {ta, tw, tk} = {pa && s_awready, pw && s_wready, pb && s_bvalid};
      if (tk)
        got = s_bresp;
      @(posedge mclk);
      if (ta)
        s_awvalid <= 1'b0;
      if (tw)
        s_wvalid <= 1'b0;
      if (tk)
        s_bready <= 1'b0;
      {pa, pw, pb} = {pa && !ta, pw && !tw, pb && !tk};
    end
    @(posedge mclk);
    check("bresp", 32'(got), 32'(resp));
  endtask

  task automatic axi_rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] resp);
    bit pa, pr, ta, tk;
    logic [1:0] got;
    logic [31:0] dat;
    int n;
    {pa, pr, n, got, dat} = {2'b11, 32'd0, 2'b11, 32'h0};
    s_araddr <= a;
    s_arvalid <= 1'b1;
    s_rready <= 1'b1;
    while ((pa || pr) && n < 100)
    begin
      @(negedge mclk);
      n++;
      {ta, tk} = {pa && s_arready, pr && s_rvalid};
      if (tk)
        {got, dat} = {s_rresp, s_rdata};
      @(posedge mclk);
      if (ta)
        s_arvalid <= 1'b0;
      if (tk)
        s_rready <= 1'b0;
      {pa, pr} = {pa && !ta, pr && !tk};
    end
    @(posedge mclk);
    check("rresp", 32'(got), 32'(resp));
    if (resp == 2'b00)
      check("rdata", dat, d);
  endtask

  task automatic drain();
    for (int i = 0; i < 3000 && exp_q.size() != 0; i++)
      @(posedge mclk);
    check("notes left", 32'(exp_q.size()), 32'h0);
  endtask

  // handshake seen settled at the negedge, taken at the next rising edge
  always @(negedge mclk)
  begin
    ptm_exp_t e;
    if (arst_n && msg_valid && msg_ready)
    begin
      if (exp_q.size() == 0)
        check("unexpected msg_tcode", 32'(msg_tcode), 32'hFFFF_FFFF);
      else
      begin
        e = exp_q.pop_front();
        check("msg_tcode", 32'(msg_tcode), 32'(e.tc));
        if (e.cnt >= 0)
          check("msg_count", 32'(msg_count), 32'(e.cnt));
        if (e.ca)
          check("msg_addr", 32'(msg_addr), 32'(e.a));
        if (e.ca)
          check("msg_addr_len", 32'(msg_addr_len), 32'(sig_len(e.a)));
        if (e.tc == ptm_pkg::TC_DSYNC_CC)
          check("msg_bitptr", 32'(msg_bitptr), 32'(e.bp));
      end
    end
  end

  always @(posedge mclk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      bad_count++;
      tally_and_finish();
    end
  end

  initial
  begin
    repeat (5) @(posedge mclk);
    arst_n <= 1'b1;
    @(posedge mclk);
    fire(1'b0, 6'h00, -1);
    axi_wr(ptm_pkg::OFS_CTRL, 32'hFFFF_FFF1, 2'b00);
    axi_rd(ptm_pkg::OFS_CTRL, 32'h0000_0001, 2'b00);
    axi_rd(8'h40, 32'h0, 2'b10);
    axi_wr(8'h44, 32'h0, 2'b10);
    axi_wr(ptm_pkg::OFS_STAT, 32'h0, 2'b00);
    run_seq(3);
    fire(1'b0, sync_code(), -1);
    for (int k = 0; k < 8; k++)
    begin
      run_seq(k);
      cause(k);
      run_seq(2);
      fire(1'b0, sync_code(), 0);
      run_seq(k);
      fire(1'b0, ptm_pkg::TC_DIRECT, k);
    end
    run_seq(5);
    fire(1'b0, ptm_pkg::TC_DIRECT, 5);
    run_seq(4);
    fire(1'b1, ptm_pkg::TC_INDIRECT, 4);
    run_seq(3);
    correct(1'b0, 1);
    run_seq(2);
    fire(1'b1, ptm_pkg::TC_INDIRECT, 3);
    run_seq(1);
    correct(1'b1, -1);
    fire(1'b1, ptm_pkg::TC_INDIRECT, 0);
    note(ptm_pkg::TC_FULL, int'(ptm_pkg::RES_SEQ_FULL), 1'b0, 23'h0, 6'h00);
    run_seq(300);
    fire(1'b0, sync_code(), -1);
    for (int i = 0; i < 255; i++)
      fire(1'b0, ptm_pkg::TC_DIRECT, 0);
    fire(1'b0, sync_code(), -1);
    drain();
    stall <= 1'b1;
    repeat (3) @(posedge mclk);
    for (int i = 0; i < 17; i++)
      fire(1'b0, 6'h00, -1);
    note(ptm_pkg::TC_ERROR, int'(ptm_pkg::ERR_OVERRUN), 1'b0, 23'h0, 6'h00);
    stall <= 1'b0;
    fire(1'b0, sync_code(), 1);
    drain();
    axi_wr(ptm_pkg::OFS_CTRL, 32'h0, 2'b00);
    fire(1'b0, 6'h00, -1);
    axi_wr(ptm_pkg::OFS_CTRL, 32'h3, 2'b00);
    fmt = 1'b1;
    fire(1'b0, sync_code(), -1);
    fire(1'b0, ptm_pkg::TC_DIRECT, 0);
    drain();
    tally_and_finish();
  end
endmodule
